/* File: remote_command_interface.sv */
// Remote command front end: AHB-Lite registers, serial and instrument bus character paths.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module remote_command_interface
   import rci_pkg::*;
#(
   parameter int unsigned BAUD_DIV = CLOCK_HZ / BAUD_RATE
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Serial link.
   input wire logic ser_rxd,
   output logic ser_txd,
   // Instrument bus byte port.
   input wire logic [7:0] gpib_rx_data,
   input wire logic gpib_rx_valid,
   input wire logic gpib_rx_eoi,
   output logic [7:0] gpib_tx_data,
   output logic gpib_tx_valid,
   output logic gpib_tx_eoi,
   input wire logic gpib_tx_ready,
   output logic gpib_holdoff,
   output logic [4:0] gpib_addr,
   output logic gpib_srq,
   // Front panel and straps.
   input wire logic local_key,
   input wire logic pon_srq_strap,
   output logic remote
);

   localparam logic [15:0] BAUD_LAST = 16'(BAUD_DIV - 1);
   localparam logic [15:0] BAUD_HALF = 16'(BAUD_DIV / 2);

   function automatic logic is_reg(input logic [31:0] a, input logic [7:0] ofs);
      is_reg = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
   endfunction : is_reg

   function automatic logic [7:0] to_upper(input logic [7:0] c);
      to_upper = (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
   endfunction : to_upper

   function automatic logic [7:0] ack_char(input logic [1:0] k, input logic [2:0] i);
      case ({k, i})
         5'h00: ack_char = 8'h4F;
         5'h01: ack_char = 8'h4B;
         5'h08: ack_char = 8'h45;
         5'h09: ack_char = 8'h52;
         5'h0A: ack_char = 8'h52;
         5'h0B: ack_char = 8'h4F;
         5'h0C: ack_char = 8'h52;
         5'h10: ack_char = 8'h54;
         5'h11: ack_char = 8'h49;
         5'h12: ack_char = 8'h4D;
         5'h13: ack_char = 8'h45;
         5'h14: ack_char = 8'h20;
         5'h15: ack_char = 8'h4F;
         5'h16: ack_char = 8'h55;
         5'h17: ack_char = 8'h54;
         default: ack_char = 8'h00;
      endcase
   endfunction : ack_char

   function automatic logic [2:0] ack_last(input logic [1:0] k);
      case (k)
         ACK_OK: ack_last = 3'h1;
         ACK_ERROR: ack_last = 3'h4;
         default: ack_last = 3'h7;
      endcase
   endfunction : ack_last

   cfg_type cfg;
   status_type status;
   tx_state_type tx_state;
   logic wr_pend;
   logic [31:0] wr_addr;
   logic started;
   logic xoff;
   logic rx_valid;
   logic overrun;
   logic query;
   logic msg_end;
   logic frame_err;
   logic [7:0] rx_char;
   logic [15:0] rxb_cnt;
   logic [3:0] rx_left;
   logic [7:0] rx_sh;
   logic ser_evt;
   logic ser_ferr;
   logic [7:0] ser_byte;
   logic [7:0] tx_char;
   logic tx_end;
   logic [1:0] ack_kind;
   logic [2:0] idx;
   logic [10:0] tx_sh;
   logic [3:0] tx_bits;
   logic [15:0] txb_cnt;

   // Bus decode.
   wire logic addr_phase = hsel && htrans[1] && hready;
   wire logic rd_phase = addr_phase && !hwrite;
   wire logic rd_rx = rd_phase && is_reg(haddr, OFS_RXDATA);
   wire logic wr_cfg = wr_pend && is_reg(wr_addr, OFS_CFG);
   wire logic wr_txd = wr_pend && is_reg(wr_addr, OFS_TXDATA);
   wire logic wr_ack = wr_pend && is_reg(wr_addr, OFS_ACK);
   wire logic wr_ctrl = wr_pend && is_reg(wr_addr, OFS_CTRL);
   wire logic hold_rel = wr_ctrl && hwdata[CTRL_HOLD_REL_BIT];
   wire logic clr_msg = wr_ctrl && hwdata[CTRL_CLR_MSG_BIT];
   wire logic clr_srq = wr_ctrl && hwdata[CTRL_CLR_SRQ_BIT];
   wire logic [31:0] rd_val = is_reg(haddr, OFS_CFG) ? {16'h0000, cfg} :
                              is_reg(haddr, OFS_STATUS) ? {23'h000000, status} :
                              is_reg(haddr, OFS_RXDATA) ? {24'h000000, rx_char} : 32'h00000000;

   // Received character routing.
   wire logic serial = cfg.link_serial;
   wire logic rx_evt = serial ? ser_evt : gpib_rx_valid;
   wire logic [7:0] rx_byte = serial ? ser_byte : gpib_rx_data;
   wire logic rx_flow = serial && (rx_byte == CH_XON || rx_byte == CH_XOFF);
   wire logic rx_cmd = rx_evt && !rx_flow;

   // Terminator selection.
   wire logic term_chars = serial ? (cfg.ser_term != ST_NONE) : (cfg.gpib_term <= GT_LF);
   wire logic term_two = serial ? (cfg.ser_term == ST_CRLF) : (cfg.gpib_term == GT_CRLF_EOI);
   wire logic term_cr = serial ? (cfg.ser_term == ST_CR) : (cfg.gpib_term == GT_CR_EOI);
   wire logic term_eoi = !serial && cfg.gpib_term != GT_LF;
   wire logic [7:0] term_first = (term_two || term_cr) ? CH_CR : CH_LF;

   // Transmit selection.
   wire logic uart_busy = tx_bits != 4'h0;
   wire logic [7:0] cur_char = (tx_state == TX_DATA) ? to_upper(tx_char) :
                               (tx_state == TX_ACK) ? ack_char(ack_kind, idx) :
                               (tx_state == TX_TERM1) ? term_first : CH_LF;
   wire logic cur_eoi = !serial && ((tx_state == TX_DATA && tx_end && cfg.gpib_term == GT_EOI) ||
                        (tx_state == TX_TERM1 && !term_two && term_eoi) ||
                        (tx_state == TX_TERM2 && term_eoi));
   // The character on the wire always finishes, so a pause costs at most one character.
   wire logic emit = tx_state != TX_IDLE &&
                     (serial ? (!uart_busy && !xoff) : (!gpib_tx_valid || gpib_tx_ready));
   wire logic start_data = wr_txd && tx_state == TX_IDLE;
   wire logic start_ack = wr_ack && tx_state == TX_IDLE && serial && !cfg.ack_silent &&
                          hwdata[1:0] != 2'h3;

   assign status = '{frame_err: frame_err, holdoff: gpib_holdoff, msg_end: msg_end,
      query: query, overrun: overrun, rx_valid: rx_valid,
      busy: tx_state != TX_IDLE || uart_busy || gpib_tx_valid, xoff: xoff, remote: remote};

   // AHB-Lite slave; reads answer with zero wait states.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         wr_pend <= 1'b0;
         wr_addr <= 32'h00000000;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= rd_phase ? rd_val : 32'h00000000;
         wr_pend <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr <= haddr;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cfg <= CFG_RESET;
         gpib_addr <= RST_BUS_ADDR;
      end else begin
         if (wr_cfg) begin
            cfg <= cfg_type'(hwdata[15:0]);
         end
         gpib_addr <= cfg.bus_addr;
      end
   end

   // Serial receiver: 8 data bits sampled mid-bit, no parity.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rxb_cnt <= 16'h0000;
         rx_left <= 4'h0;
         rx_sh <= 8'h00;
         ser_evt <= 1'b0;
         ser_ferr <= 1'b0;
         ser_byte <= 8'h00;
      end else begin
         ser_evt <= 1'b0;
         ser_ferr <= 1'b0;
         if (rx_left == 4'h0) begin
            if (!ser_rxd) begin
               rx_left <= RX_SAMPLES;
               rxb_cnt <= BAUD_HALF;
            end
         end else if (rxb_cnt != 16'h0000) begin
            rxb_cnt <= rxb_cnt - 16'h0001;
         end else begin
            rxb_cnt <= BAUD_LAST;
            rx_left <= rx_left - 4'h1;
            if (rx_left == RX_SAMPLES && ser_rxd) begin
               rx_left <= 4'h0;
            end else if (rx_left == 4'h1) begin
               ser_evt <= ser_rxd;
               ser_ferr <= !ser_rxd;
               ser_byte <= rx_sh;
            end else if (rx_left != RX_SAMPLES) begin
               rx_sh <= {ser_rxd, rx_sh[7:1]};
            end
         end
      end
   end

   // Message tracking; a hardware set always wins over a clear in the same cycle.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         started <= 1'b0;
         gpib_srq <= 1'b0;
         remote <= 1'b0;
         xoff <= 1'b0;
         rx_valid <= 1'b0;
         overrun <= 1'b0;
         query <= 1'b0;
         msg_end <= 1'b0;
         gpib_holdoff <= 1'b0;
         frame_err <= 1'b0;
         rx_char <= 8'h00;
      end else begin
         started <= 1'b1;
         if (!started) begin
            gpib_srq <= pon_srq_strap;
         end else if (clr_srq) begin
            gpib_srq <= 1'b0;
         end
         if (local_key) begin
            remote <= 1'b0;
         end
         if (rx_cmd) begin
            remote <= 1'b1;
         end
         if (rx_evt && rx_flow) begin
            xoff <= rx_byte == CH_XOFF;
         end
         if (rd_rx) begin
            rx_valid <= 1'b0;
         end
         if (rx_cmd) begin
            rx_valid <= 1'b1;
            rx_char <= to_upper(rx_byte);
         end
         if (clr_msg) begin
            overrun <= 1'b0;
            query <= 1'b0;
            msg_end <= 1'b0;
            frame_err <= 1'b0;
         end
         if (rx_cmd && rx_valid && !rd_rx) begin
            overrun <= 1'b1;
         end
         if (rx_cmd && rx_byte == CH_QUERY) begin
            query <= 1'b1;
         end
         if (rx_cmd && (rx_byte == CH_LF || (!serial && gpib_rx_eoi))) begin
            msg_end <= 1'b1;
         end
         if (serial && ser_ferr) begin
            frame_err <= 1'b1;
         end
         if (hold_rel) begin
            gpib_holdoff <= 1'b0;
         end
         if (rx_cmd && !serial && rx_byte == CH_HOLD) begin
            gpib_holdoff <= 1'b1;
         end
      end
   end

   // Response, acknowledge and terminator sequencer.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_state <= TX_IDLE;
         tx_char <= 8'h00;
         tx_end <= 1'b0;
         ack_kind <= ACK_OK;
         idx <= 3'h0;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               if (start_data) begin
                  tx_state <= TX_DATA;
                  tx_char <= hwdata[7:0];
                  tx_end <= hwdata[TXD_END_BIT];
               end else if (start_ack) begin
                  tx_state <= TX_ACK;
                  ack_kind <= hwdata[1:0];
                  idx <= 3'h0;
               end
            end
            TX_DATA: begin
               if (emit) begin
                  tx_state <= (tx_end && term_chars) ? TX_TERM1 : TX_IDLE;
               end
            end
            TX_ACK: begin
               if (emit && idx == ack_last(ack_kind)) begin
                  tx_state <= term_chars ? TX_TERM1 : TX_IDLE;
               end else if (emit) begin
                  idx <= idx + 3'h1;
               end
            end
            TX_TERM1: begin
               if (emit) begin
                  tx_state <= term_two ? TX_TERM2 : TX_IDLE;
               end
            end
            TX_TERM2: begin
               if (emit) begin
                  tx_state <= TX_IDLE;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Instrument bus output holds each character until the bus side takes it.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         gpib_tx_data <= 8'h00;
         gpib_tx_eoi <= 1'b0;
         gpib_tx_valid <= 1'b0;
      end else if (emit && !serial) begin
         gpib_tx_data <= cur_char;
         gpib_tx_eoi <= cur_eoi;
         gpib_tx_valid <= 1'b1;
      end else if (gpib_tx_ready) begin
         gpib_tx_valid <= 1'b0;
      end
   end

   // Serial transmitter: start bit, 8 data bits, two stop bits.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_sh <= 11'h7FF;
         tx_bits <= 4'h0;
         txb_cnt <= 16'h0000;
         ser_txd <= 1'b1;
      end else begin
         ser_txd <= tx_sh[0];
         if (emit && serial) begin
            tx_sh <= {2'b11, cur_char, 1'b0};
            tx_bits <= FRAME_BITS;
            txb_cnt <= BAUD_LAST;
         end else if (uart_busy) begin
            if (txb_cnt != 16'h0000) begin
               txb_cnt <= txb_cnt - 16'h0001;
            end else begin
               txb_cnt <= BAUD_LAST;
               tx_sh <= {1'b1, tx_sh[10:1]};
               tx_bits <= tx_bits - 4'h1;
            end
         end
      end
   end

endmodule : remote_command_interface
`default_nettype wire

/* File: rci_pkg.sv */
// Constants, register map and types shared by the remote command interface.
package rci_pkg;
   localparam int unsigned CLOCK_HZ = 250000000;
   localparam int unsigned BAUD_RATE = 9600;
   localparam logic [3:0] FRAME_BITS = 4'hB;
   localparam logic [3:0] RX_SAMPLES = 4'hA;

   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RXDATA = 8'h08;
   localparam logic [7:0] OFS_TXDATA = 8'h0C;
   localparam logic [7:0] OFS_ACK = 8'h10;
   localparam logic [7:0] OFS_CTRL = 8'h14;

   localparam int unsigned TXD_END_BIT = 8;
   localparam int unsigned CTRL_HOLD_REL_BIT = 0;
   localparam int unsigned CTRL_CLR_MSG_BIT = 1;
   localparam int unsigned CTRL_CLR_SRQ_BIT = 2;

   localparam logic [4:0] RST_BUS_ADDR = 5'h01;
   localparam logic [2:0] GT_CRLF_EOI = 3'h0;
   localparam logic [2:0] GT_CR_EOI = 3'h1;
   localparam logic [2:0] GT_LF_EOI = 3'h2;
   localparam logic [2:0] GT_LF = 3'h3;
   localparam logic [2:0] GT_EOI = 3'h4;
   localparam logic [1:0] ST_CRLF = 2'h0;
   localparam logic [1:0] ST_CR = 2'h1;
   localparam logic [1:0] ST_LF = 2'h2;
   localparam logic [1:0] ST_NONE = 2'h3;
   localparam logic [1:0] ACK_OK = 2'h0;
   localparam logic [1:0] ACK_ERROR = 2'h1;
   localparam logic [1:0] ACK_TIMEOUT = 2'h2;

   localparam logic [7:0] CH_XON = 8'h11;
   localparam logic [7:0] CH_XOFF = 8'h13;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_QUERY = 8'h3F;
   localparam logic [7:0] CH_HOLD = 8'h40;

   typedef struct packed {
      logic [3:0] mcb_addr;
      logic link_serial;
      logic ack_silent;
      logic [1:0] ser_term;
      logic [2:0] gpib_term;
      logic [4:0] bus_addr;
   } cfg_type;

   localparam cfg_type CFG_RESET = '{mcb_addr: 4'h0, link_serial: 1'b0, ack_silent: 1'b1,
      ser_term: ST_CRLF, gpib_term: GT_CRLF_EOI, bus_addr: RST_BUS_ADDR};

   typedef struct packed {
      logic frame_err;
      logic holdoff;
      logic msg_end;
      logic query;
      logic overrun;
      logic rx_valid;
      logic busy;
      logic xoff;
      logic remote;
   } status_type;

   typedef enum {TX_IDLE, TX_DATA, TX_ACK, TX_TERM1, TX_TERM2} tx_state_type;
endpackage : rci_pkg

/* File: rci_monitor.sv */
// Concurrent checks on the ports of the remote command interface.
`timescale 1ns/1ns
`default_nettype none
module rci_monitor
   import rci_pkg::*;
#(
   parameter int unsigned BAUD_DIV = 8
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Instrument bus.
   input wire logic [7:0] gpib_rx_data,
   input wire logic gpib_rx_valid,
   input wire logic [7:0] gpib_tx_data,
   input wire logic gpib_tx_valid,
   input wire logic gpib_tx_eoi,
   input wire logic gpib_tx_ready,
   input wire logic gpib_holdoff,
   input wire logic [4:0] gpib_addr,
   input wire logic gpib_srq,
   // Serial line, panel and strap.
   input wire logic ser_txd,
   input wire logic local_key,
   input wire logic pon_srq_strap,
   input wire logic remote
);
   logic txd_last;
   logic [15:0] run_len;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Run length of the current line level; it saturates so long idle spells never wrap.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         txd_last <= 1'b1;
         run_len <= 16'h0000;
      end else begin
         txd_last <= ser_txd;
         run_len <= (ser_txd != txd_last) ? 16'h0001 : run_len + {15'h0000, ~&run_len};
      end
   end
   sequence hold_char_s;
      gpib_rx_valid && gpib_rx_data == CH_HOLD;
   endsequence
   sequence tx_stall_s;
      gpib_tx_valid && !gpib_tx_ready;
   endsequence
   addr_default_a: assert property (
      $past(sys_rst) |-> gpib_addr == RST_BUS_ADDR) else $error("Bus address is not 1 after reset.");
   srq_poweron_a: assert property (
      $past(sys_rst) |=> gpib_srq == $past(pon_srq_strap)) else $error("Power-on service request wrong.");
   remote_enter_a: assert property (
      gpib_rx_valid && !local_key |-> ##[1:3] remote) else $error("Remote state not entered.");
   remote_stay_a: assert property (
      remote && !local_key |=> remote) else $error("Remote state left without the local key.");
   local_key_a: assert property (
      local_key && !gpib_rx_valid |-> ##[1:2] !remote) else $error("Local key did not leave remote.");
   holdoff_set_a: assert property (
      hold_char_s |-> ##[1:3] gpib_holdoff) else $error("Hold-off not raised by at-sign.");
   tx_hold_a: assert property (
      tx_stall_s |=> gpib_tx_valid && $stable(gpib_tx_data) && $stable(gpib_tx_eoi)) else $error("Bus char dropped.");
   upper_case_a: assert property (
      gpib_tx_valid |-> !(gpib_tx_data inside {[8'h61:8'h7A]})) else $error("Lower-case response char.");
   bit_time_a: assert property (
      ser_txd && !txd_last |-> run_len % BAUD_DIV == 0) else $error("Serial low level not whole bits.");
endmodule : rci_monitor
bind remote_command_interface rci_monitor #(.BAUD_DIV(BAUD_DIV)) mon_u (.clock, .sys_rst, .gpib_rx_data,
   .gpib_rx_valid, .gpib_tx_data, .gpib_tx_valid, .gpib_tx_eoi, .gpib_tx_ready, .gpib_holdoff, .gpib_addr,
   .gpib_srq, .ser_txd, .local_key, .pon_srq_strap, .remote);
`default_nettype wire

/* File: serial_host_model.sv */
// Serial host model: sends framed characters and collects what the device transmits.
`timescale 1ns/1ns
`default_nettype none
module serial_host_model #(
   parameter int unsigned BIT_CYC = 8
)
(
   // Clock.
   input wire logic clock,
   // Serial pair as seen from the device.
   output logic ser_rxd,
   input wire logic ser_txd
);
   logic [7:0] got[$];
   logic paused = 1'b0;
   initial ser_rxd = 1'b1;
   // Eight data bits, no parity, two stop bits; the line rests at mark between frames.
   task send_char(input logic [7:0] c);
      logic [10:0] frame;
      // A stop code from the device holds our characters back until it resumes, for a bounded time.
      for (int w = 0; w < 4000 && paused; w++) @(posedge clock);
      frame = {2'b11, c, 1'b0};
      for (int i = 0; i < 11; i++) begin
         ser_rxd <= frame[i];
         repeat (BIT_CYC) @(posedge clock);
      end
   endtask : send_char
   // A frame with a bad stop bit is stored as zero, so a comparison against any nonzero character fails.
   always begin : take_frame
      logic [7:0] c;
      @(negedge ser_txd);
      repeat (BIT_CYC / 2) @(posedge clock);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT_CYC) @(posedge clock);
         if (i < 8) c[i] = ser_txd;
         else if (ser_txd !== 1'b1) c = 8'h00;
      end
      got.push_back(c);
      if (c == 8'h13) paused = 1'b1;
      else if (c == 8'h11) paused = 1'b0;
   end
endmodule : serial_host_model
`default_nettype wire

/* File: remote_command_interface_tb.sv */
// Self-checking testbench for the remote command interface.
`timescale 1ns/1ns
`default_nettype none
module remote_command_interface_tb;
   import rci_pkg::*;
   logic clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp, ser_rxd, ser_txd, remote, local_key;
   logic gpib_rx_valid, gpib_rx_eoi, gpib_tx_ready, gpib_tx_valid, gpib_tx_eoi, gpib_holdoff, gpib_srq, pon_srq_strap;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] gpib_rx_data, gpib_tx_data;
   logic [4:0] gpib_addr;
   int errors, n_tests;
   string ack_txt[3] = '{"OK", "ERROR", "TIME OUT"};
   assign hready = hreadyout;
   remote_command_interface #(.BAUD_DIV(8)) dut_u (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .ser_rxd, .ser_txd, .gpib_rx_data, .gpib_rx_valid,
      .gpib_rx_eoi, .gpib_tx_data, .gpib_tx_valid, .gpib_tx_eoi, .gpib_tx_ready, .gpib_holdoff, .gpib_addr,
      .gpib_srq, .local_key, .pon_srq_strap, .remote);
   serial_host_model #(.BIT_CYC(8)) host_u (.clock, .ser_rxd, .ser_txd);
   task end_sim;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task tmo(input int i);
      if (i >= 400) begin
         errors++;
         $display("wrong value wait expected done seen timeout");
         end_sim;
      end
   endtask : tmo
   // Called just after a rising edge; each phase is held until hready is seen high.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      i = 0;
      do begin @(posedge clock); i++; end while (hready !== 1'b1 && i < 400);
      tmo(i);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      i = 0;
      do begin @(posedge clock); i++; end while (hready !== 1'b1 && i < 400);
      tmo(i);
      q = hrdata;
      chk("hresp", 32'h0, {31'h00000000, hresp});
   endtask : bus
   task wait_idle;
      int i;
      i = 0;
      do begin bus(1'b0, OFS_STATUS, 32'h0); i++; end while (q[2] !== 1'b0 && i < 400);
      tmo(i);
   endtask : wait_idle
   task ser_expect(input string s);
      int i;
      for (int k = 0; k < s.len(); k++) begin
         i = 0;
         while (host_u.got.size() == 0 && i < 400) begin @(posedge clock); i++; end
         tmo(i);
         chk("serial char", s[k], host_u.got.pop_front());
      end
   endtask : ser_expect
   // The taker stalls three cycles before each char, so the port must hold its output.
   task gpib_expect(input logic [7:0] c, input logic eoi);
      int i;
      repeat (3) @(posedge clock);
      i = 0;
      while (gpib_tx_valid !== 1'b1 && i < 400) begin @(posedge clock); i++; end
      tmo(i);
      chk("bus char", c, gpib_tx_data);
      chk("bus eoi", eoi, gpib_tx_eoi);
      gpib_tx_ready <= 1'b1;
      @(posedge clock);
      gpib_tx_ready <= 1'b0;
   endtask : gpib_expect
   task t_reset;
      bus(1'b1, 8'h20, 32'hFFFFFFFF);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b0, OFS_CFG, 32'h0);
      chk("cfg reset", 32'h00000401, q);
      chk("bus address", 5'h01, gpib_addr);
      chk("srq", 1'b0, gpib_srq);
   endtask : t_reset
   task t_bus_term;
      for (int t = 0; t < 5; t++) begin
         bus(1'b1, OFS_CFG, {16'h0000, 4'h0, 2'b01, 2'h0, 3'(t), 5'h01});
         wait_idle;
         bus(1'b1, OFS_TXDATA, 32'h00000161);
         gpib_expect(8'h41, t == 4);
         if (t < 2) gpib_expect(CH_CR, t == 1);
         if (t != 1 && t != 4) gpib_expect(CH_LF, t != 3);
      end
   endtask : t_bus_term
   task t_serial;
      bus(1'b1, OFS_CFG, 32'h00000801);
      for (int c = 0; c < 3; c++) begin
         wait_idle;
         bus(1'b1, OFS_ACK, 32'(c));
         ser_expect({ack_txt[c], "\r\n"});
      end
      bus(1'b1, OFS_CFG, 32'h00000B01);
      wait_idle;
      bus(1'b1, OFS_ACK, 32'h0);
      ser_expect("OK");
      bus(1'b1, OFS_CFG, 32'h00000901);
      wait_idle;
      bus(1'b1, OFS_TXDATA, 32'h0000017A);
      ser_expect("Z\r");
      bus(1'b1, OFS_CFG, 32'h00000D01);
      bus(1'b1, OFS_ACK, 32'h0);
      repeat (300) @(posedge clock);
      chk("silent ack", 32'h0, 32'(host_u.got.size()));
   endtask : t_serial
   task t_rx_remote;
      host_u.send_char(8'h76);
      repeat (10) @(posedge clock);
      bus(1'b0, OFS_RXDATA, 32'h0);
      chk("rx char", 32'h56, q);
      chk("remote", 1'b1, remote);
      host_u.send_char(CH_QUERY);
      host_u.send_char(CH_LF);
      repeat (10) @(posedge clock);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("query flag", 1'b1, q[5]);
      chk("message end", 1'b1, q[6]);
      local_key <= 1'b1;
      repeat (3) @(posedge clock);
      local_key <= 1'b0;
      @(posedge clock);
      chk("remote", 1'b0, remote);
   endtask : t_rx_remote
   task t_flow;
      host_u.send_char(CH_XOFF);
      repeat (10) @(posedge clock);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("paused", 1'b1, q[1]);
      bus(1'b1, OFS_TXDATA, 32'h00000042);
      repeat (300) @(posedge clock);
      chk("held chars", 32'h0, 32'(host_u.got.size()));
      host_u.send_char(CH_XON);
      ser_expect("B");
   endtask : t_flow
   // A second reset with the strap set; it also returns the link to the instrument bus.
   task t_srq;
      pon_srq_strap <= 1'b1;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      chk("srq", 1'b1, gpib_srq);
      bus(1'b1, OFS_CTRL, 32'h00000004);
      @(posedge clock);
      chk("srq", 1'b0, gpib_srq);
      pon_srq_strap <= 1'b0;
   endtask : t_srq
   task t_holdoff;
      gpib_rx_data <= CH_HOLD;
      gpib_rx_valid <= 1'b1;
      @(posedge clock);
      gpib_rx_valid <= 1'b0;
      repeat (3) @(posedge clock);
      chk("holdoff", 1'b1, gpib_holdoff);
      chk("remote", 1'b1, remote);
      bus(1'b1, OFS_CTRL, 32'h00000001);
      repeat (2) @(posedge clock);
      chk("holdoff", 1'b0, gpib_holdoff);
   endtask : t_holdoff
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      errors = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {gpib_rx_data, gpib_rx_valid, gpib_rx_eoi, gpib_tx_ready, local_key, pon_srq_strap} = '0;
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      t_reset;
      t_bus_term;
      t_serial;
      t_rx_remote;
      t_flow;
      t_srq;
      t_holdoff;
      end_sim;
   end
endmodule : remote_command_interface_tb
`default_nettype wire
